// ### verilog/addr_gen_pkg.sv
package addr_gen_pkg;

  // ****************************************************************
  // Register offsets (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_CS_DESC   = 8'h04;
  localparam logic [7:0] OFS_SEG_BASE  = 8'h08;
  localparam logic [7:0] OFS_SEG_SEL   = 8'h0c;
  localparam logic [7:0] OFS_OFFSET    = 8'h10;
  localparam logic [7:0] OFS_PREFIX    = 8'h14;
  localparam logic [7:0] OFS_PAGE_IDX  = 8'h18;
  localparam logic [7:0] OFS_PAGE_FRM  = 8'h1c;
  localparam logic [7:0] OFS_GO        = 8'h20;
  localparam logic [7:0] OFS_STATUS    = 8'h24;
  localparam logic [7:0] OFS_LIN_ADDR  = 8'h28;
  localparam logic [7:0] OFS_PHYS_LO   = 8'h2c;
  localparam logic [7:0] OFS_PHYS_HI   = 8'h30;
  localparam logic [7:0] OFS_NEXT_IP   = 8'h34;
  localparam logic [7:0] OFS_FLAGS     = 8'h38;
  localparam logic [7:0] OFS_GPR0      = 8'h40;

  // ****************************************************************
  // Field positions and limits
  // ****************************************************************
  localparam int          CTRL_MODE_LSB   = 0;
  localparam int          CTRL_PAGING_BIT = 2;
  localparam int          CTRL_MODEL_LSB  = 3;
  localparam int          STAT_FAULT_BIT  = 0;
  localparam int          STAT_DONE_BIT   = 1;
  localparam int          PAGE_SHIFT      = 12;
  localparam logic [31:0] LIMIT_16        = 32'h0000ffff;
  localparam logic [31:0] LIMIT_32        = 32'hffffffff;
  localparam logic [31:0] LIMIT_REAL      = 32'h000fffff;
  localparam logic [15:0] MAX_SEGMENTS    = 16'h3fff - 16'h0001;
  localparam logic [31:0] FLAGS_RESET     = 32'h00000002;
  localparam logic [31:0] IP_RESET        = 32'h0000fff0;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_REAL      = 2'b00,
    MODE_PROTECTED = 2'b01,
    MODE_SYS_MGMT  = 2'b11
  } op_mode_t;

  typedef enum logic [1:0] {
    MODEL_FLAT      = 2'b00,
    MODEL_SEGMENTED = 2'b01,
    MODEL_REAL      = 2'b10
  } mem_model_t;

  typedef struct packed {
    logic        addr_ovr;
    logic        opnd_ovr;
  } prefix_t;

  typedef struct packed {
    logic        fault;
    logic        addr32;
    logic        opnd32;
    logic [31:0] linear;
    logic [35:0] phys;
  } xlate_t;

endpackage

// ### verilog/segmented_address_generator.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: Physical memory is a sequence of bytes, each with its own address.
// R2: Physical addresses run from zero to two to the thirty-six minus one.
// R3: Linear space is byte addressed, zero to two to the thirty-two minus one.
// R4: Logical address is 16-bit selector plus 32-bit or 16-bit offset.
// R5: Up to 16,383 segments, each up to four gigabytes.
// R6: Every access turns logical into linear, unseen by the program.
// R7: Paging off: linear address goes out unchanged as physical address.
// R8: Paging on: linear pages map through a table to physical frames.
// R9: Offset limit FFFFH at 16-bit size, all ones at 32-bit size.
// R10: Operand size 8 or 32 at 32-bit setting, 8 or 16 at 16-bit.
// R11: Prefixes override default address size, operand size, or both.
// R12: Protected mode takes default sizes from the code segment descriptor.
// R13: Real-address mode defaults to 16-bit address and operand sizes.
// R14: Real-address mode caps linear addresses at 000FFFFFH despite overrides.
// R15: Real-address mode segments are 64 KB; linear space is 2^20 bytes.
// R16: Real-address mode allows only the real-address memory model.
// R17: Protected mode allows flat, segmented or real-address model.
// R18: System management mode uses separate memory, real-like addressing.
// R19: Wide physical space reached only through paging of linear spaces.
// R20: Sixteen execution registers: eight general, six selectors, flags, pointer. The block keeps one selector, seg_sel_r.
// R21: Instruction pointer holds a 32-bit pointer to the next instruction.
// R22: After reset the block starts in real-address mode.
module segmented_address_generator #(
  parameter int PAGE_ENTRIES      = 16,
  parameter int SYS_MGMT_RAM_BASE = 32'h00030000
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [35:0]      phys_addr,
  output logic             phys_valid
);
  import addr_gen_pkg::*;

  localparam int PIDX_W = $clog2(PAGE_ENTRIES);

  // ****************************************************************
  // Architectural state
  // ****************************************************************
  // Mode and size
  op_mode_t                 mode_r;
  mem_model_t               model_r;
  logic                     paging_r;
  logic                     cs_d32_r;
  logic [31:0]              seg_base_r;
  logic [15:0]              seg_sel_r;
  logic [31:0]              offset_r;
  prefix_t                  prefix_r;

  // Page table and registers
  logic [PIDX_W-1:0]        page_idx_r;
  logic [23:0]              frame_r [PAGE_ENTRIES];
  logic [31:0]              next_instr_pointer_r;
  logic [31:0]              program_status_flags_r;
  logic [31:0]              gpr_r [8];

  // Last translation
  xlate_t                   result_r;
  logic                     done_r;
  xlate_t                   xl_nxt;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  // Held write halves
  logic       aw_held_r;
  logic       w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic       wr_fire;
  logic       wr_hit;

  // Free slot; commit when both held
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;

  // Capture address and data independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Decode of writable offsets
  always_comb begin
    case (aw_addr_r)
      OFS_CTRL, OFS_CS_DESC, OFS_SEG_BASE, OFS_SEG_SEL, OFS_OFFSET,
      OFS_PREFIX, OFS_PAGE_IDX, OFS_PAGE_FRM, OFS_GO, OFS_NEXT_IP,
      OFS_FLAGS: wr_hit = 1'b1;
      default: wr_hit = (aw_addr_r[7:5] == OFS_GPR0[7:5]) && (aw_addr_r[1:0] == 2'b00);
    endcase
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        v[8*b +: 8] = d[8*b +: 8];
      end
    end
    return v;
  endfunction

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic [31:0] ctrl_w;
  logic [31:0] sel_w;
  logic [31:0] frm_w;

  // Words merged with the write
  assign ctrl_w = merge({27'h0, model_r, paging_r, mode_r}, w_data_r, w_strb_r);
  assign sel_w  = merge({16'h0, seg_sel_r}, w_data_r, w_strb_r);
  assign frm_w  = merge({8'h0, frame_r[page_idx_r]}, w_data_r, w_strb_r);

  // Mode, model and paging; reset lands in real-address mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r   <= MODE_REAL;                             // [R22]
      model_r  <= MODEL_REAL;
      paging_r <= 1'b0;
    end else if (wr_fire && aw_addr_r == OFS_CTRL) begin
      // Only protected mode picks a model
      if (op_mode_t'(ctrl_w[CTRL_MODE_LSB +: 2]) == MODE_PROTECTED) begin
        mode_r   <= MODE_PROTECTED;
        model_r  <= (ctrl_w[CTRL_MODEL_LSB +: 2] == 2'b11) ? MODEL_FLAT
                    : mem_model_t'(ctrl_w[CTRL_MODEL_LSB +: 2]); // [R17]
        paging_r <= ctrl_w[CTRL_PAGING_BIT];
      end else begin
        mode_r   <= (ctrl_w[CTRL_MODE_LSB +: 2] == 2'b11) ? MODE_SYS_MGMT : MODE_REAL;
        model_r  <= MODEL_REAL;                          // [R16] [R18]
        paging_r <= 1'b0;                                // [R19]
      end
    end
  end

  // Segment, offset, prefixes and code segment default size
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_d32_r   <= 1'b0;
      seg_base_r <= 32'h00000000;
      seg_sel_r  <= 16'h0000;
      offset_r   <= 32'h00000000;
      prefix_r   <= '0;
      page_idx_r <= '0;
    end else if (wr_fire) begin
      case (aw_addr_r)
        OFS_CS_DESC:  cs_d32_r   <= w_strb_r[0] ? w_data_r[0] : cs_d32_r;
        OFS_SEG_BASE: seg_base_r <= merge(seg_base_r, w_data_r, w_strb_r);
        OFS_SEG_SEL:  seg_sel_r  <= sel_w[15:0]; // [R4]
        OFS_OFFSET:   offset_r   <= merge(offset_r, w_data_r, w_strb_r);
        OFS_PREFIX:   prefix_r   <= w_strb_r[0] ? prefix_t'(w_data_r[1:0]) : prefix_r; // [R11]
        OFS_PAGE_IDX: page_idx_r <= w_strb_r[0] ? w_data_r[PIDX_W-1:0] : page_idx_r;
        default: ;
      endcase
    end
  end

  // Page table entries, one frame number per linear page
  generate
    for (genvar i = 0; i < PAGE_ENTRIES; i++) begin : g_page
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          frame_r[i] <= 24'h000000;
        end else if (wr_fire && aw_addr_r == OFS_PAGE_FRM && page_idx_r == PIDX_W'(i)) begin
          frame_r[i] <= frm_w[23:0]; // [R8]
        end
      end
    end
  endgenerate

  // Execution registers: eight general, flags and instruction pointer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      next_instr_pointer_r   <= IP_RESET;                 // [R21]
      program_status_flags_r <= FLAGS_RESET;
      for (int g = 0; g < 8; g++) begin
        gpr_r[g] <= 32'h00000000;                         // [R20]
      end
    end else if (wr_fire) begin
      if (aw_addr_r == OFS_NEXT_IP) begin
        next_instr_pointer_r <= merge(next_instr_pointer_r, w_data_r, w_strb_r);
      end
      // Flag bit 1 always reads as one
      if (aw_addr_r == OFS_FLAGS) begin
        program_status_flags_r <= merge(program_status_flags_r, w_data_r, w_strb_r) | FLAGS_RESET;
      end
      if (wr_hit && aw_addr_r[7:5] == OFS_GPR0[7:5]) begin
        gpr_r[aw_addr_r[4:2]] <= merge(gpr_r[aw_addr_r[4:2]], w_data_r, w_strb_r);
      end
    end
  end

  // ****************************************************************
  // Translation path
  // ****************************************************************
  always_comb begin
    logic [31:0] off;
    logic [31:0] lin;
    logic [31:0] lim;
    logic        a32;
    off = 32'h0;
    lin = 32'h0;
    lim = LIMIT_16;
    a32 = 1'b0;
    xl_nxt = '0;
    // Default size from the mode, flipped by a prefix
    if (mode_r == MODE_PROTECTED) begin
      a32 = cs_d32_r ^ prefix_r.addr_ovr;                         // [R12] [R11]
      xl_nxt.opnd32 = cs_d32_r ^ prefix_r.opnd_ovr;               // [R10]
    end else begin
      a32 = prefix_r.addr_ovr;                                    // [R13]
      xl_nxt.opnd32 = prefix_r.opnd_ovr;
    end
    xl_nxt.addr32 = a32;
    // Limit and offset follow the size
    lim = a32 ? LIMIT_32 : LIMIT_16;                              // [R9]
    off = a32 ? offset_r : {16'h0, offset_r[15:0]};               // [R4]
    if (mode_r == MODE_PROTECTED && model_r != MODEL_REAL) begin
      // Flat ignores the base; segmented adds the selected base
      lin = (model_r == MODEL_FLAT) ? off : seg_base_r + off;     // [R3] [R6]
      // Raw offset, so a 16-bit access cannot hide an overflow
      xl_nxt.fault = (offset_r > lim) ||                          // [R9]
                     (model_r == MODEL_SEGMENTED && seg_sel_r[15:2] > MAX_SEGMENTS[13:0]); // [R5]
    end else begin
      // Real-like: selector times sixteen plus offset, wrapped to 1 MB
      lin = ({16'h0, seg_sel_r} << 4) + off;                      // [R15]
      xl_nxt.fault = (offset_r > lim) || (a32 && offset_r > LIMIT_REAL); // [R14]
      lin = lin & LIMIT_REAL;
      if (mode_r == MODE_SYS_MGMT) begin
        lin = lin + SYS_MGMT_RAM_BASE[31:0];                      // [R18]
      end
    end
    // Direct or paged physical address
    xl_nxt.linear = lin;
    if (paging_r) begin
      xl_nxt.phys = {frame_r[lin[PAGE_SHIFT +: PIDX_W]], lin[PAGE_SHIFT-1:0]}; // [R8] [R19]
    end else begin
      xl_nxt.phys = {4'h0, lin};                                  // [R7]
    end
  end

  // A write to GO latches one translation and, unless it faults, issues the byte address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_r   <= '0;
      done_r     <= 1'b0;
      phys_valid <= 1'b0;
      phys_addr  <= 36'h000000000;
    end else begin
      phys_valid <= 1'b0;
      if (wr_fire && aw_addr_r == OFS_GO) begin
        result_r   <= xl_nxt;
        done_r     <= 1'b1;
        phys_valid <= !xl_nxt.fault;                              // [R1]
        // A fault keeps the last address on the lines
        if (!xl_nxt.fault) begin
          phys_addr <= xl_nxt.phys;                               // [R2]
        end
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  // Read mux output
  logic [31:0] rd_val;
  logic        rd_hit;

  // New read once the answer is taken
  assign s_axi_arready = !s_axi_rvalid;

  // Read mux of status and state
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h00000000;
    case (s_axi_araddr)
      OFS_CTRL:     rd_val = {27'h0, model_r, paging_r, mode_r};
      OFS_CS_DESC:  rd_val = {31'h0, cs_d32_r};
      OFS_SEG_BASE: rd_val = seg_base_r;
      OFS_SEG_SEL:  rd_val = {16'h0, seg_sel_r};
      OFS_OFFSET:   rd_val = offset_r;
      OFS_PREFIX:   rd_val = {30'h0, prefix_r};
      OFS_PAGE_IDX: rd_val = 32'(page_idx_r);
      OFS_PAGE_FRM: rd_val = {8'h0, frame_r[page_idx_r]};
      OFS_GO:       rd_val = 32'h00000000;
      OFS_STATUS:   rd_val = {28'h0, result_r.opnd32, result_r.addr32, done_r, result_r.fault};
      OFS_LIN_ADDR: rd_val = result_r.linear;
      OFS_PHYS_LO:  rd_val = result_r.phys[31:0];
      OFS_PHYS_HI:  rd_val = {28'h0, result_r.phys[35:32]};
      OFS_NEXT_IP:  rd_val = next_instr_pointer_r;
      OFS_FLAGS:    rd_val = program_status_flags_r;
      default: begin
        // General registers at the top
        rd_hit = (s_axi_araddr[7:5] == OFS_GPR0[7:5]) && (s_axi_araddr[1:0] == 2'b00);
        rd_val = rd_hit ? gpr_r[s_axi_araddr[4:2]] : 32'h00000000;
      end
    endcase
  end

  // Read data register, held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ### verification/addr_gen_sva.sv
`timescale 1ns/1ps
module addr_gen_sva
  import addr_gen_pkg::*;
#(
  parameter int PAGE_ENTRIES = 16
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [35:0] phys_addr,
  input wire logic        phys_valid
);
  // ****************************************************************
  // Bus timing and translation issue
  // ****************************************************************
  AST_READ_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  AST_READ_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while answer pending");
  AST_READ_DONE: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer not retired");
  AST_WRITE_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_WRITE_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write accepted while response pending");
  AST_WRITE_DONE: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response not retired");
  AST_PHYS_WITH_RESP: assert property (@(posedge aclk) disable iff (!aresetn)
    phys_valid |-> $rose(s_axi_bvalid)) else $error("address issued without write response");
  AST_PHYS_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
    phys_valid |=> !phys_valid) else $error("address strobe longer than one cycle");
  AST_PHYS_STABLE: assert property (@(posedge aclk) disable iff (!aresetn)
    !phys_valid |-> $stable(phys_addr)) else $error("address moved without strobe");
  AST_RESET_STATE: assert property (@(posedge aclk)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !phys_valid && phys_addr == 36'h0)
    else $error("outputs not cleared by reset");
  // Main scenarios reached
  COV_PHYS: cover property (@(posedge aclk) disable iff (!aresetn) phys_valid);
  COV_WRITE: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
  COV_READ: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
endmodule

bind segmented_address_generator addr_gen_sva #(.PAGE_ENTRIES(PAGE_ENTRIES)) chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .phys_addr(phys_addr), .phys_valid(phys_valid));

// ### verification/phys_mem_model.sv
`timescale 1ns/1ps
module phys_mem_model (
  input wire logic        aclk,
  input wire logic [35:0] phys_addr,
  input wire logic        phys_valid,
  output int              hits
);
  logic [7:0] mem [logic [35:0]];

  // Each strobed address names one byte cell of the wide space
  always @(posedge aclk) begin
    if (phys_valid === 1'b1) begin
      mem[phys_addr] = phys_addr[7:0];
      hits = hits + 1;
    end
  end
endmodule

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
  import addr_gen_pkg::*;
  typedef struct packed {logic [31:0] v; logic [31:0] m; logic [1:0] r;} rexp_t;
  localparam logic [31:0] SYS_RAM_BASE = 32'h00030000; // Design default
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, phys_valid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, r0, r1;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [35:0] phys_addr;
  logic [15:0] s0;
  rexp_t       rq[$];
  rexp_t       ex;
  logic [1:0]  bq[$];
  logic [35:0] pq[$];
  int          n_fail, samples_checked, cyc, hits, n_phys;

  segmented_address_generator uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .phys_addr(phys_addr), .phys_valid(phys_valid));
  phys_mem_model mem (.aclk(aclk), .phys_addr(phys_addr), .phys_valid(phys_valid), .hits(hits));

  // 40 MHz clock
  always #12.5 aclk = ~aclk;

  // ****************************************************************
  // Checking
  // ****************************************************************
  task automatic miss(input logic [35:0] e, input logic [35:0] g);
    n_fail++;
    $display("unexpected at %0t ns: expected %h got %h", $time, e, g);
  endtask
  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) miss({4'h0, e}, {4'h0, g});
  endtask
  task automatic cmp_rsp(input logic [1:0] e, input logic [1:0] g);
    samples_checked++;
    if (g !== e) miss({34'h0, e}, {34'h0, g});
  endtask
  task automatic cmp_ph(input logic [35:0] e, input logic [35:0] g);
    samples_checked++;
    if (g !== e) miss(e, g);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Results are matched against the oldest note of their kind
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      ex = rq.pop_front();
      cmp_rd(ex.v & ex.m, s_axi_rdata & ex.m);
      cmp_rsp(ex.r, s_axi_rresp);
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) cmp_rsp(bq.pop_front(), s_axi_bresp);
    if (phys_valid === 1'b1) begin
      if (pq.size() == 0) miss(36'h0, phys_addr);
      else cmp_ph(pq.pop_front(), phys_addr);
    end
  end

  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Bus master tasks
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    bq.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m, input logic [1:0] e);
    rq.push_back(rexp_t'{v, m, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
  endtask
  // One translation: set up, start, then read status under a mask
  task automatic xl(input logic [31:0] ctl, desc, base, input logic [15:0] sel, input logic [31:0] off,
                    input logic [1:0] pfx, input logic flt, input logic [35:0] ph, input logic [31:0] st, msk);
    wr(OFS_CTRL, ctl, RESP_OKAY);
    wr(OFS_CS_DESC, desc, RESP_OKAY);
    wr(OFS_SEG_BASE, base, RESP_OKAY);
    wr(OFS_SEG_SEL, {16'h0, sel}, RESP_OKAY);
    wr(OFS_OFFSET, off, RESP_OKAY);
    wr(OFS_PREFIX, {30'h0, pfx}, RESP_OKAY);
    if (!flt) pq.push_back(ph);
    if (!flt) n_phys++;
    wr(OFS_GO, 32'h1, RESP_OKAY);
    rd(OFS_STATUS, st, msk, RESP_OKAY);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    r0 = $urandom(63629);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_CTRL, 32'h10, 32'h1f, RESP_OKAY);
    rd(OFS_FLAGS, 32'h2, 32'hffffffff, RESP_OKAY);
    rd(OFS_NEXT_IP, 32'hfff0, 32'hffffffff, RESP_OKAY);
    $display("test reset state done");
    for (int i = 0; i < 8; i++) begin
      r0 = $urandom;
      wr(OFS_GPR0 + 8'(4 * i), r0, RESP_OKAY);
      rd(OFS_GPR0 + 8'(4 * i), r0, 32'hffffffff, RESP_OKAY);
    end
    wr(8'h80, 32'h1, RESP_SLVERR);
    rd(8'h80, 32'h0, 32'hffffffff, RESP_SLVERR);
    wr(OFS_CTRL, 32'h08, RESP_OKAY);
    rd(OFS_CTRL, 32'h10, 32'h1f, RESP_OKAY);
    wr(OFS_CTRL, 32'h09, RESP_OKAY);
    rd(OFS_CTRL, 32'h09, 32'h1f, RESP_OKAY);
    wr(OFS_CTRL, 32'h03, RESP_OKAY);
    rd(OFS_CTRL, 32'h13, 32'h1f, RESP_OKAY);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      s0 = 16'($urandom);
      r0 = $urandom & 32'hffff;
      r1 = (({16'h0, s0} << 4) + r0) & 32'h000fffff;
      xl(32'h10, 32'h1, 32'h0, s0, r0, 2'b00, 1'b0, {4'h0, r1}, 32'h2, 32'hf);
    end
    xl(32'h10, 32'h1, 32'h0, 16'h0, 32'h000f0000, 2'b11, 1'b0, 36'h0f0000, 32'he, 32'hf);
    xl(32'h10, 32'h1, 32'h0, 16'h0, 32'h00100000, 2'b10, 1'b1, 36'h0, 32'h5, 32'hd);
    $display("test real mode done");
    r0 = $urandom;
    xl(32'h01, 32'h1, 32'h0, 16'h8, r0, 2'b00, 1'b0, {4'h0, r0}, 32'he, 32'hf);
    r0 = $urandom & 32'hffff;
    xl(32'h01, 32'h1, 32'h0, 16'h8, r0, 2'b11, 1'b0, {4'h0, r0}, 32'h2, 32'hf);
    xl(32'h01, 32'h0, 32'h0, 16'h8, r0, 2'b01, 1'b0, {4'h0, r0}, 32'ha, 32'hf);
    r1 = $urandom;
    xl(32'h09, 32'h0, r1, 16'h10, 32'hffff, 2'b00, 1'b0, {4'h0, r1 + 32'hffff}, 32'h2, 32'hf);
    xl(32'h09, 32'h0, r1, 16'h10, 32'h10000, 2'b00, 1'b1, 36'h0, 32'h1, 32'hd);
    xl(32'h09, 32'h1, 32'h0, 16'h10, 32'hffffffff, 2'b00, 1'b0, 36'h0ffffffff, 32'he, 32'hf);
    xl(32'h09, 32'h1, 32'h0, 16'hffff, 32'h0, 2'b00, 1'b1, 36'h0, 32'hd, 32'hd);
    $display("test protected mode done");
    r1 = $urandom & 32'h00ffffff;
    r0 = 32'h00003000 | ($urandom & 32'hfff);
    wr(OFS_PAGE_IDX, 32'h3, RESP_OKAY);
    wr(OFS_PAGE_FRM, r1, RESP_OKAY);
    xl(32'h05, 32'h1, 32'h0, 16'h8, r0, 2'b00, 1'b0, {r1[23:0], r0[11:0]}, 32'he, 32'hf);
    rd(OFS_PHYS_LO, {r1[19:0], r0[11:0]}, 32'hffffffff, RESP_OKAY);
    rd(OFS_PHYS_HI, {28'h0, r1[23:20]}, 32'hf, RESP_OKAY);
    $display("test paging done");
    s0 = 16'($urandom);
    r0 = $urandom & 32'hffff;
    r1 = ((({16'h0, s0} << 4) + r0) & 32'h000fffff) + SYS_RAM_BASE;
    xl(32'h03, 32'h1, 32'h0, s0, r0, 2'b00, 1'b0, {4'h0, r1}, 32'h2, 32'h3);
    $display("test system management done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_CTRL, 32'h10, 32'h1f, RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp_rd(32'(n_phys), 32'(hits));
    $display("test reset again done");
    end_of_test();
  end
endmodule
